//--- hdl/stall_pkg.sv
package stall_pkg;

	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;

	// Register word offsets
	localparam logic [3:0] ADDR_CTRL     = 4'h0;
	localparam logic [3:0] ADDR_OC_THR   = 4'h1;
	localparam logic [3:0] ADDR_OC_GAIN  = 4'h2;
	localparam logic [3:0] ADDR_HS_COEF  = 4'h3;
	localparam logic [3:0] ADDR_OV_THR   = 4'h4;
	localparam logic [3:0] ADDR_OV_FGAIN = 4'h5;
	localparam logic [3:0] ADDR_OV_VGAIN = 4'h6;
	localparam logic [3:0] ADDR_OV_RISE  = 4'h7;
	localparam logic [3:0] ADDR_OVEXC    = 4'h8;
	localparam logic [3:0] ADDR_OSC      = 4'h9;
	localparam logic [3:0] ADDR_RATED    = 4'hA;
	localparam logic [3:0] ADDR_RAMP     = 4'hB;
	localparam logic [3:0] ADDR_STATUS   = 4'hC;
	localparam logic [3:0] ADDR_OUT_FREQ = 4'hD;
	localparam logic [3:0] ADDR_EFF_THR  = 4'hE;

	// Field positions in the control word
	localparam int CTRL_OC_EN_BIT = 0;
	localparam int CTRL_OV_EN_BIT = 1;

	// Values after reset and documented ranges
	localparam logic [7:0]  OC_THR_RST    = 8'h96;
	localparam logic [15:0] OC_THR_MIN    = 16'h0032;
	localparam logic [15:0] OC_THR_MAX    = 16'h00C8;
	localparam logic [7:0]  OC_GAIN_RST   = 8'h14;
	localparam logic [7:0]  HS_COEF_RST   = 8'h32;
	localparam logic [15:0] HS_COEF_MIN   = 16'h0032;
	localparam logic [15:0] HS_COEF_MAX   = 16'h00C8;
	localparam logic [15:0] OV_THR_RST    = 16'h1E14;
	localparam logic [15:0] OV_THR_MIN    = 16'h07D0;
	localparam logic [15:0] OV_THR_MAX    = 16'h4E20;
	localparam logic [7:0]  OV_FGAIN_RST  = 8'h1E;
	localparam logic [7:0]  OV_VGAIN_RST  = 8'h1E;
	localparam logic [7:0]  OV_RISE_RST   = 8'h05;
	localparam logic [15:0] OV_RISE_MAX   = 16'h0032;
	localparam logic [7:0]  OVEXC_RST     = 8'h40;
	localparam logic [15:0] OVEXC_MAX     = 16'h00C8;
	localparam logic [15:0] GAIN_MAX      = 16'h0064;
	localparam logic [7:0]  OSC_RST       = 8'h14;
	localparam logic [15:0] RATED_RST     = 16'h1388;
	localparam logic [15:0] RAMP_RST      = 16'h000A;

	// Scale factors: current in 0.1 %, frequency in 0.01 Hz
	localparam logic [7:0]  PCT_SCALE     = 8'h0A;
	localparam logic [7:0]  HZ_SCALE      = 8'h64;
	localparam logic [7:0]  HS_NEUTRAL    = 8'h32;
	localparam int          OC_SHIFT      = 4;
	localparam int          OV_SHIFT      = 6;
	localparam int          OSC_SHIFT     = 8;
	localparam int          DIV_STEPS     = 36;

	// Control update period
	localparam int CLK_PERIOD_NS  = 100;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic        oc_en;
		logic        ov_en;
		logic [7:0]  oc_thr;
		logic [7:0]  oc_gain;
		logic [7:0]  hs_coef;
		logic [15:0] ov_thr;
		logic [7:0]  ov_fgain;
		logic [7:0]  ov_vgain;
		logic [7:0]  ov_rise;
		logic [7:0]  overexc;
		logic [7:0]  osc_gain;
		logic [15:0] rated_freq;
		logic [15:0] ramp_step;
	} settings_type;

	typedef struct packed {
		logic high_speed;
		logic ov_active;
		logic oc_active;
	} status_type;

	typedef enum logic [1:0] {
		ST_WAIT  = 2'h0,
		ST_DIV   = 2'h1,
		ST_APPLY = 2'h3
	} state_type;

endpackage : stall_pkg

//--- hdl/seq_divider.sv
`timescale 1ns/1ps
`default_nettype none
module seq_divider
	import stall_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Operands
	input  wire logic        start,
	input  wire logic [35:0] num,
	input  wire logic [23:0] den,
	// Result
	output logic             done,
	output logic [35:0]      quot
);

	logic [24:0] rem_r, rem_nxt;
	logic [35:0] q_r, q_nxt;
	logic [5:0]  cnt_r, cnt_nxt;
	logic        busy_r, busy_nxt;
	logic        done_r, done_nxt;
	logic [24:0] shifted;

	always_comb begin
		rem_nxt  = rem_r;
		q_nxt    = q_r;
		cnt_nxt  = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		shifted  = {rem_r[23:0], q_r[35]};
		if (start && !busy_r) begin
			rem_nxt  = '0;
			q_nxt    = num;
			cnt_nxt  = '0;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			if (shifted >= {1'b0, den}) begin
				rem_nxt = shifted - {1'b0, den};
				q_nxt   = {q_r[34:0], 1'b1};
			end else begin
				rem_nxt = shifted;
				q_nxt   = {q_r[34:0], 1'b0};
			end
			cnt_nxt = cnt_r + 6'h01;
			if (cnt_r == 6'(DIV_STEPS - 1)) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rem_r  <= '0;
			q_r    <= '0;
			cnt_r  <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else if (ce) begin
			rem_r  <= rem_nxt;
			q_r    <= q_nxt;
			cnt_r  <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
	assign quot = q_r;

endmodule : seq_divider
`default_nettype wire

//--- hdl/vf_stall_prevention_limiter.sv
// Overview of operation
// - Overcurrent lowers output frequency until current drops
// - Below threshold, frequency ramps back toward target
// - Overcurrent threshold 50..200 percent, default 150
// - Overcurrent stall enable bit, on after reset
// - Overcurrent gain 0..100, default 20, scales pullback
// - Above rated frequency, threshold times rated over running
// - Coefficient 50..200, default 50, 50 means none
// - Bus overvoltage raises frequency, lengthening deceleration
// - Overvoltage threshold 200.0..2000.0 V, default 770.0
// - Overvoltage stall enable bit, on after reset
// - Overvoltage frequency gain 0..100, default 30
// - Overvoltage voltage gain 0..100, default 30
// - Frequency rise during overvoltage capped, 0..50 Hz
// - Overexcitation gain 0..200, default 64, strengthens
// - Oscillation damping gain 0..100 damps output
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vf_stall_prevention_limiter
	import stall_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)(
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Register port
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic [15:0]      rd_data,
	// Measurements and target
	input  wire logic [15:0] target_freq,
	input  wire logic [15:0] motor_current,
	input  wire logic [15:0] bus_voltage,
	// Power stage command and status
	output logic [15:0]      out_freq,
	output logic             oc_stall_active,
	output logic             ov_stall_active
);

	settings_type set_r, set_nxt;
	state_type    st_r, st_nxt;
	status_type   stat_r, stat_nxt;
	logic [31:0]  tick_r, tick_nxt;
	logic [15:0]  out_r, out_nxt;
	logic [15:0]  thr_r, thr_nxt;
	logic [15:0]  ov_base_r, ov_base_nxt;
	logic [15:0]  dv_prev_r, dv_prev_nxt;
	logic [15:0]  rd_r, rd_nxt;
	logic         div_start, div_done;
	logic [35:0]  div_quot;
	logic [15:0]  base_thr;
	logic         high_speed, oc_hit, ov_hit;

	function automatic logic [7:0] clip8(input logic [15:0] v, input logic [15:0] lo,
			input logic [15:0] hi);
		logic [15:0] c;
		c = (v < lo) ? lo : ((v > hi) ? hi : v);
		return c[7:0];
	endfunction : clip8

	// Register writes, clamped to the legal range
	always_comb begin
		set_nxt = set_r;
		if (wr_en) begin
			if (addr == ADDR_CTRL) begin
				set_nxt.oc_en = wr_data[CTRL_OC_EN_BIT];
				set_nxt.ov_en = wr_data[CTRL_OV_EN_BIT];
			end else if (addr == ADDR_OC_THR) begin
				set_nxt.oc_thr = clip8(wr_data, OC_THR_MIN, OC_THR_MAX);
			end else if (addr == ADDR_OC_GAIN) begin
				set_nxt.oc_gain = clip8(wr_data, 16'h0000, GAIN_MAX);
			end else if (addr == ADDR_HS_COEF) begin
				set_nxt.hs_coef = clip8(wr_data, HS_COEF_MIN, HS_COEF_MAX);
			end else if (addr == ADDR_OV_THR) begin
				set_nxt.ov_thr = (wr_data < OV_THR_MIN) ? OV_THR_MIN :
					((wr_data > OV_THR_MAX) ? OV_THR_MAX : wr_data);
			end else if (addr == ADDR_OV_FGAIN) begin
				set_nxt.ov_fgain = clip8(wr_data, 16'h0000, GAIN_MAX);
			end else if (addr == ADDR_OV_VGAIN) begin
				set_nxt.ov_vgain = clip8(wr_data, 16'h0000, GAIN_MAX);
			end else if (addr == ADDR_OV_RISE) begin
				set_nxt.ov_rise = clip8(wr_data, 16'h0000, OV_RISE_MAX);
			end else if (addr == ADDR_OVEXC) begin
				set_nxt.overexc = clip8(wr_data, 16'h0000, OVEXC_MAX);
			end else if (addr == ADDR_OSC) begin
				set_nxt.osc_gain = clip8(wr_data, 16'h0000, GAIN_MAX);
			end else if (addr == ADDR_RATED) begin
				set_nxt.rated_freq = wr_data;
			end else if (addr == ADDR_RAMP) begin
				set_nxt.ramp_step = wr_data;
			end
		end
	end

	// Read port: data stands one cycle, zero otherwise
	always_comb begin
		rd_nxt = '0;
		if (rd_en) begin
			if (addr == ADDR_CTRL) begin
				rd_nxt = {14'h0000, set_r.ov_en, set_r.oc_en};
			end else if (addr == ADDR_OC_THR) begin
				rd_nxt = {8'h00, set_r.oc_thr};
			end else if (addr == ADDR_OC_GAIN) begin
				rd_nxt = {8'h00, set_r.oc_gain};
			end else if (addr == ADDR_HS_COEF) begin
				rd_nxt = {8'h00, set_r.hs_coef};
			end else if (addr == ADDR_OV_THR) begin
				rd_nxt = set_r.ov_thr;
			end else if (addr == ADDR_OV_FGAIN) begin
				rd_nxt = {8'h00, set_r.ov_fgain};
			end else if (addr == ADDR_OV_VGAIN) begin
				rd_nxt = {8'h00, set_r.ov_vgain};
			end else if (addr == ADDR_OV_RISE) begin
				rd_nxt = {8'h00, set_r.ov_rise};
			end else if (addr == ADDR_OVEXC) begin
				rd_nxt = {8'h00, set_r.overexc};
			end else if (addr == ADDR_OSC) begin
				rd_nxt = {8'h00, set_r.osc_gain};
			end else if (addr == ADDR_RATED) begin
				rd_nxt = set_r.rated_freq;
			end else if (addr == ADDR_RAMP) begin
				rd_nxt = set_r.ramp_step;
			end else if (addr == ADDR_STATUS) begin
				rd_nxt = {13'h0000, stat_r};
			end else if (addr == ADDR_OUT_FREQ) begin
				rd_nxt = out_r;
			end else if (addr == ADDR_EFF_THR) begin
				rd_nxt = thr_r;
			end
		end
	end

	assign base_thr   = 16'(set_r.oc_thr * PCT_SCALE);
	assign high_speed = out_r > set_r.rated_freq;
	assign oc_hit     = set_r.oc_en && (motor_current > thr_r);
	assign ov_hit     = set_r.ov_en && (bus_voltage > set_r.ov_thr);
	// Compensation only runs above rated frequency and with a non-neutral coefficient
	assign div_start  = (st_r == ST_WAIT) && (tick_r == 32'(TICK_LEN - 1)) && high_speed
		&& (set_r.hs_coef != HS_NEUTRAL);

	seq_divider u_div (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.start   (div_start),
		.num     (36'(base_thr * set_r.rated_freq * set_r.hs_coef)),
		.den     (24'(out_r * HZ_SCALE)),
		.done    (div_done),
		.quot    (div_quot)
	);

	logic [16:0] ramp_f, cap_f;
	logic [15:0] cand, dv, dv_rise, oc_err, mag, dmag;
	logic [19:0] oc_dec, ov_inc;
	logic [25:0] ov_sum;
	logic [16:0] raised;
	logic        neg;

	// Control sequencing and frequency update
	always_comb begin
		st_nxt      = st_r;
		tick_nxt    = tick_r;
		thr_nxt     = thr_r;
		out_nxt     = out_r;
		stat_nxt    = stat_r;
		ov_base_nxt = ov_base_r;
		dv_prev_nxt = dv_prev_r;
		ramp_f      = {1'b0, out_r};
		cap_f       = 17'(ov_base_r + set_r.ov_rise * HZ_SCALE);
		dv          = bus_voltage - set_r.ov_thr;
		dv_rise     = (dv > dv_prev_r) ? dv - dv_prev_r : 16'h0000;
		oc_err      = motor_current - thr_r;
		oc_dec      = 20'((24'(set_r.oc_gain) * 24'(oc_err)) >> OC_SHIFT);
		ov_sum      = 26'(set_r.ov_fgain * dv) + 26'(set_r.ov_vgain * dv_rise)
			+ 26'(set_r.overexc * dv);
		ov_inc      = ov_sum[25:OV_SHIFT];
		raised      = 17'h00000;
		cand        = out_r;
		mag         = '0;
		dmag        = '0;
		neg         = 1'b0;
		case (st_r)
			ST_WAIT: begin
				tick_nxt = tick_r + 32'h00000001;
				if (tick_r == 32'(TICK_LEN - 1)) begin
					tick_nxt = '0;
					if (div_start) begin
						st_nxt = ST_DIV;
					end else begin
						thr_nxt = base_thr;
						st_nxt  = ST_APPLY;
					end
				end
			end
			ST_DIV: begin
				if (div_done) begin
					// Never raise the threshold above the base setting
					thr_nxt = (div_quot < {20'h00000, base_thr}) ? div_quot[15:0] : base_thr;
					st_nxt  = ST_APPLY;
				end
			end
			ST_APPLY: begin
				if (out_r < target_freq) begin
					ramp_f = 17'(out_r + set_r.ramp_step);
					if (ramp_f > {1'b0, target_freq}) begin
						ramp_f = {1'b0, target_freq};
					end
				end else if (out_r > target_freq) begin
					ramp_f = (out_r - target_freq > set_r.ramp_step) ?
						17'(out_r - set_r.ramp_step) : {1'b0, target_freq};
				end
				if (oc_hit) begin
					// At least one step so the pullback cannot stall at gain 0
					if (oc_dec == 20'h00000) begin
						oc_dec = 20'h00001;
					end
					cand = (oc_dec >= {4'h0, out_r}) ? 16'h0000 : 16'(out_r - oc_dec);
				end else if (ov_hit) begin
					raised = (ov_inc > 20'h0FFFF) ? 17'h0FFFF : 17'(out_r + ov_inc);
					if (!stat_r.ov_active) begin
						cap_f = 17'(out_r + set_r.ov_rise * HZ_SCALE);
					end
					if (raised > cap_f) begin
						raised = (cap_f > {1'b0, out_r}) ? cap_f : {1'b0, out_r};
					end
					// Saturate rather than wrap when the cap sits above full scale
					cand = raised[16] ? 16'hFFFF : raised[15:0];
				end else begin
					cand = ramp_f[15:0];
				end
				// Damping trims each step but never to zero, so it cannot freeze the output
				neg  = cand < out_r;
				mag  = neg ? out_r - cand : cand - out_r;
				dmag = mag - 16'((24'(mag) * 24'(set_r.osc_gain)) >> OSC_SHIFT);
				out_nxt = neg ? out_r - dmag : out_r + dmag;
				if (ov_hit && !oc_hit && !stat_r.ov_active) begin
					ov_base_nxt = out_r;
				end
				dv_prev_nxt         = ov_hit ? dv : 16'h0000;
				stat_nxt.oc_active  = oc_hit;
				stat_nxt.ov_active  = ov_hit && !oc_hit;
				stat_nxt.high_speed = high_speed;
				st_nxt              = ST_WAIT;
			end
			default: begin
				st_nxt = ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			set_r <= '{oc_en: 1'b1, ov_en: 1'b1, oc_thr: OC_THR_RST, oc_gain: OC_GAIN_RST,
				hs_coef: HS_COEF_RST, ov_thr: OV_THR_RST, ov_fgain: OV_FGAIN_RST,
				ov_vgain: OV_VGAIN_RST, ov_rise: OV_RISE_RST, overexc: OVEXC_RST,
				osc_gain: OSC_RST, rated_freq: RATED_RST, ramp_step: RAMP_RST};
			st_r      <= ST_WAIT;
			stat_r    <= '0;
			tick_r    <= '0;
			out_r     <= '0;
			thr_r     <= {8'h00, OC_THR_RST} * {8'h00, PCT_SCALE};
			ov_base_r <= '0;
			dv_prev_r <= '0;
			rd_r      <= '0;
		end else if (ce) begin
			set_r     <= set_nxt;
			st_r      <= st_nxt;
			stat_r    <= stat_nxt;
			tick_r    <= tick_nxt;
			out_r     <= out_nxt;
			thr_r     <= thr_nxt;
			ov_base_r <= ov_base_nxt;
			dv_prev_r <= dv_prev_nxt;
			rd_r      <= rd_nxt;
		end
	end

	assign rd_data         = rd_r;
	assign out_freq        = out_r;
	assign oc_stall_active = stat_r.oc_active;
	assign ov_stall_active = stat_r.ov_active;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_div_begin;
		ce && div_start ##1 st_r == ST_DIV;
	endsequence
	sequence s_div_finish;
		##[1:40] st_r == ST_APPLY;
	endsequence

	a_oc_pulls_down: assert property (
		ce && st_r == ST_APPLY && oc_hit && out_r != 16'h0000 |=> out_r < $past(out_r))
		else $error("frequency not lowered during overcurrent");
	a_thr_in_range: assert property (
		set_r.oc_thr >= OC_THR_MIN[7:0] && set_r.oc_thr <= OC_THR_MAX[7:0])
		else $error("overcurrent threshold out of range");
	a_enables_reset: assert property (
		$fell(rst) |-> set_r.oc_en && set_r.ov_en)
		else $error("stall functions not enabled after reset");
	a_hs_divides: assert property (
		s_div_begin |-> s_div_finish ##1 thr_r <= $past(base_thr))
		else $error("compensated threshold late or above base");
	a_neutral_coef: assert property (
		ce && st_r == ST_WAIT && tick_r == 32'(TICK_LEN - 1) && set_r.hs_coef == HS_NEUTRAL
		|=> thr_r == $past(base_thr))
		else $error("neutral coefficient changed the threshold");
	a_ov_raises: assert property (
		ce && st_r == ST_APPLY && ov_hit && !oc_hit |=> out_r >= $past(out_r))
		else $error("frequency fell during overvoltage stall");
	a_ov_rise_cap: assert property (
		ov_stall_active |-> {1'b0, out_r} <= 17'(ov_base_r + set_r.ov_rise * HZ_SCALE))
		else $error("frequency rose past the overvoltage limit");
	a_plain_ramp: assert property (
		ce && st_r == ST_APPLY && !oc_hit && !ov_hit && out_r < target_freq
		&& set_r.osc_gain == 8'h00 && set_r.ramp_step != 16'h0000 |=> out_r > $past(out_r))
		else $error("ramp stalled with no stall condition");
	a_read_out: assert property (
		ce && rd_en && addr == ADDR_OUT_FREQ |=> rd_data == $past(out_r) ##1 rd_data == 16'h0000
		|| $past(rd_en))
		else $error("read data wrong or held too long");

endmodule : vf_stall_prevention_limiter
`default_nettype wire

//--- bench/power_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Frequency command from the limiter
	input  wire logic [15:0] out_freq,
	// Load conditions chosen by the bench
	input  wire logic [15:0] load_current,
	input  wire logic [15:0] link_voltage,
	// Measurements back to the limiter
	output logic [15:0]      motor_current,
	output logic [15:0]      bus_voltage
);
	logic [15:0] cur_r;
	logic [15:0] cur_nxt;
	logic [15:0] volt_r;
	logic [15:0] volt_nxt;

	// A stopped inverter draws no current; sensing adds one cycle as an ADC would
	always_comb begin
		cur_nxt = (out_freq == 16'h0000) ? 16'h0000 : load_current;
		volt_nxt = link_voltage;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur_r <= 16'h0000;
			volt_r <= 16'h1770;
		end else begin
			cur_r <= cur_nxt;
			volt_r <= volt_nxt;
		end
	end

	assign motor_current = cur_r;
	assign bus_voltage = volt_r;
endmodule : power_stage_model
`default_nettype wire

//--- bench/vf_stall_prevention_limiter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vf_stall_prevention_limiter_tb_top
	import stall_pkg::*;
;
	localparam int TICK = 20;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wr_data = 16'h0000;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [15:0] rd_data;
	logic [15:0] target_freq = 16'h0000;
	logic [15:0] motor_current;
	logic [15:0] bus_voltage;
	logic [15:0] out_freq;
	logic        oc_stall_active;
	logic        ov_stall_active;
	logic [15:0] load_current = 16'h0000;
	logic [15:0] link_voltage = 16'h1770;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          seed = 58;
	logic [15:0] v;
	logic [15:0] g;
	logic [15:0] e;
	logic [15:0] o0;
	logic [15:0] w;
	logic [3:0]  lim_a [8] = '{ADDR_OC_GAIN, ADDR_OV_FGAIN, ADDR_OV_VGAIN, ADDR_OV_RISE,
		ADDR_OVEXC, ADDR_OSC, ADDR_OC_THR, ADDR_HS_COEF};
	logic [15:0] lim_lo [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		OC_THR_MIN, HS_COEF_MIN};
	logic [15:0] lim_hi [8] = '{GAIN_MAX, GAIN_MAX, GAIN_MAX, OV_RISE_MAX, OVEXC_MAX, GAIN_MAX,
		OC_THR_MAX, HS_COEF_MAX};

	always #50 sys_clk = ~sys_clk;

	vf_stall_prevention_limiter #(.TICK_LEN(TICK)) DUT (
		.sys_clk(sys_clk), .rst(rst), .ce(ce), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .target_freq(target_freq),
		.motor_current(motor_current), .bus_voltage(bus_voltage), .out_freq(out_freq),
		.oc_stall_active(oc_stall_active), .ov_stall_active(ov_stall_active));

	power_stage_model stage (
		.sys_clk(sys_clk), .rst(rst), .out_freq(out_freq), .load_current(load_current),
		.link_voltage(link_voltage), .motor_current(motor_current), .bus_voltage(bus_voltage));

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		check($sformatf("register %h", a), rd_data, exp);
	endtask : rdchk

	task automatic ticks(input int n);
		repeat (n * TICK) @(posedge sys_clk);
	endtask : ticks

	task automatic wait_change(input logic [15:0] prev);
		int n;
		n = 0;
		while (out_freq === prev && n < 4 * TICK) begin
			@(negedge sys_clk);
			n++;
		end
	endtask : wait_change

	function automatic logic [15:0] clampr(input logic [15:0] x, lo, hi);
		return (x < lo) ? lo : ((x > hi) ? hi : x);
	endfunction : clampr

	function automatic logic [15:0] drop(input int gain, input int excess);
		int d;
		d = (gain * excess) >> OC_SHIFT;
		return (d == 0) ? 16'h0001 : 16'(d);
	endfunction : drop

	function automatic logic [15:0] eff(input int thr, input int rated, input int k, input int run);
		int r;
		r = thr * rated * k / (run * 100);
		return (k == 50 || r > thr) ? 16'(thr) : 16'(r);
	endfunction : eff

	// Step after damping: the raw step loses its osc/256 share
	function automatic logic [15:0] damp(input int m, input int osc);
		return 16'(m - ((m * osc) >> OSC_SHIFT));
	endfunction : damp

	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		rdchk(ADDR_CTRL, 16'h0003);
		rdchk(ADDR_OC_THR, 16'h0096);
		rdchk(ADDR_OC_GAIN, 16'h0014);
		rdchk(ADDR_HS_COEF, 16'h0032);
		rdchk(ADDR_OV_THR, 16'h1E14);
		rdchk(ADDR_OV_FGAIN, 16'h001E);
		rdchk(ADDR_OV_VGAIN, 16'h001E);
		rdchk(ADDR_OV_RISE, 16'h0005);
		rdchk(ADDR_OVEXC, 16'h0040);
		rdchk(ADDR_EFF_THR, 16'h05DC);
		rdchk(ADDR_OSC, 16'h0014);
		rdchk(ADDR_STATUS, 16'h0000);
		rdchk(4'hF, 16'h0000);
		$display("test defaults done");
		for (int j = 0; j < 8; j++) begin
			for (int i = 0; i < 3; i++) begin
				v = 16'($random(seed) & 32'hFF);
				wr(lim_a[j], v);
				rdchk(lim_a[j], clampr(v, lim_lo[j], lim_hi[j]));
			end
		end
		wr(ADDR_OV_THR, 16'h0064);
		rdchk(ADDR_OV_THR, OV_THR_MIN);
		wr(ADDR_OV_THR, 16'hFFFF);
		rdchk(ADDR_OV_THR, OV_THR_MAX);
		$display("test ranges done");
		// Second reset restores every setting before the control tests
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		wr(ADDR_OSC, 16'h0000);
		wr(ADDR_RAMP, 16'h0032);
		target_freq <= 16'h03E8;
		ticks(25);
		check("ramp end", out_freq, 16'h03E8);
		check("flags idle", {14'h0000, ov_stall_active, oc_stall_active}, 16'h0000);
		rdchk(ADDR_OUT_FREQ, 16'h03E8);
		// Clock enable low must freeze the loop even with a new target
		@(posedge sys_clk);
		ce <= 1'b0;
		target_freq <= 16'h0000;
		ticks(3);
		check("frozen", out_freq, 16'h03E8);
		ce <= 1'b1;
		target_freq <= 16'h03E8;
		$display("test ramp done");
		for (int i = 0; i < 4; i++) begin
			g = 16'(($random(seed) & 32'h7FFF) % 101);
			e = 16'(1 + (($random(seed) & 32'h7FFF) % 100));
			wr(ADDR_OC_GAIN, g);
			o0 = out_freq;
			load_current <= 16'd1500 + e;
			wait_change(o0);
			check("oc drop", o0 - out_freq, drop(g, e));
			check("oc flag", {15'h0000, oc_stall_active}, 16'h0001);
			@(posedge sys_clk);
			load_current <= 16'h0100;
			ticks(25);
			check("oc recover", out_freq, 16'h03E8);
		end
		$display("test overcurrent done");
		link_voltage <= 16'h1F40;
		ticks(15);
		check("ov cap", out_freq, 16'h03E8 + 16'd500);
		check("ov flag", {15'h0000, ov_stall_active}, 16'h0001);
		wr(ADDR_CTRL, 16'h0001);
		ticks(15);
		check("ov off", out_freq, 16'h03E8);
		check("ov flag off", {15'h0000, ov_stall_active}, 16'h0000);
		link_voltage <= 16'h1770;
		wr(ADDR_CTRL, 16'h0002);
		load_current <= 16'h0640;
		ticks(3);
		check("oc off", out_freq, 16'h03E8);
		check("oc flag off", {15'h0000, oc_stall_active}, 16'h0000);
		load_current <= 16'h0100;
		wr(ADDR_CTRL, 16'h0003);
		$display("test enables done");
		// A bus error of 64 makes the first raw step the sum of the three gains
		for (int i = 0; i < 2; i++) begin
			g = 16'(($random(seed) & 32'h7FFF) % 101);
			v = 16'(($random(seed) & 32'h7FFF) % 101);
			e = 16'(($random(seed) & 32'h7FFF) % 201);
			w = 16'(($random(seed) & 32'h7FFF) % 101);
			wr(ADDR_OV_FGAIN, g);
			wr(ADDR_OV_VGAIN, v);
			wr(ADDR_OVEXC, e);
			wr(ADDR_OSC, w);
			wr(ADDR_OV_RISE, 16'h0032);
			o0 = out_freq;
			link_voltage <= OV_THR_RST + 16'h0040;
			wait_change(o0);
			check("ov step", out_freq - o0, damp(g + v + e, w));
			@(posedge sys_clk);
			link_voltage <= 16'h1770;
			wr(ADDR_OSC, 16'h0000);
			ticks(12);
			check("ov release", out_freq, 16'h03E8);
		end
		$display("test overvoltage gains done");
		wr(ADDR_RATED, 16'h01F4);
		for (int k = 50; k <= 200; k += 50) begin
			wr(ADDR_HS_COEF, 16'(k));
			ticks(6);
			rdchk(ADDR_EFF_THR, eff(1500, 500, k, 1000));
		end
		rdchk(ADDR_STATUS, 16'h0004);
		wr(ADDR_HS_COEF, 16'h0064);
		ticks(6);
		load_current <= 16'h0320;
		o0 = out_freq;
		wait_change(o0);
		check("hs oc flag", {15'h0000, oc_stall_active}, 16'h0001);
		$display("test high speed done");
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		$display("watchdog expired");
		finish_test();
	end
endmodule : vf_stall_prevention_limiter_tb_top
`default_nettype wire
